/* File: logic/gpio_top.sv */
// Two-port GPIO block with pull-ups, pin sharing and edge interrupt.
// Assumes an Avalon-MM master on clk_sys and pins outside the domain.
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_params.svh"
module gpio_top import gpio_pkg::*; (
    // Clock and resets
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic por_bor_rst,
    // Avalon-MM slave
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Interrupt
    output logic irq,
    // First port pins
    input wire logic [`PORT_W-1:0] pin_b_in,
    output var pin_drive_t pin_b_drive,
    output logic [`PORT_W-1:0] pin_b_pullup,
    output logic [`PORT_W-1:0] pin_b_lcd_own,
    // Second port pins
    input wire logic [`PORT_W-1:0] pin_c_in,
    output var pin_drive_t pin_c_drive,
    output logic [`PORT_W-1:0] pin_c_lcd_own,
    // Alternate owners: debug lines on first, peripherals on second
    input wire periph_drive_t b_alt,
    input wire periph_drive_t c_alt
);

    // ==========================================================
    // Register state
    logic any_rst;
    logic [`PORT_W-1:0] lat_b_q;
    logic [`PORT_W-1:0] lat_c_q;
    logic [`PORT_W-1:0] dir_b_q;
    logic [`PORT_W-1:0] dir_c_q;
    logic [`PORT_W-1:0] pullup_en_q;
    logic [3:0] chg_en_q;
    logic [`PORT_W-1:0] intctl_q;
    logic [`PORT_W-1:0] lcdctl_q;
    logic [`PORT_W-1:0] seg_lo_q;
    logic [`PORT_W-1:0] seg_hi_q;
    logic [3:0] cfg_q;
    logic [`IRQ_W-1:0] irq_sts_q;
    logic [`IRQ_W-1:0] irq_en_q;
    logic [`PORT_W-1:0] b_prev_q;

    // Either reset source clears the ordinary state
    assign any_rst = rst | por_bor_rst;

    // ==========================================================
    // Pin synchronisers
    logic [`PORT_W-1:0] sync_b;
    logic [`PORT_W-1:0] sync_c;

    pin_sync #(.WIDTH(`PORT_W)) u_sync_b (
        .clk_sys(clk_sys),
        .rst(any_rst),
        .async_in(pin_b_in),
        .sync_out(sync_b)
    );

    pin_sync #(.WIDTH(`PORT_W)) u_sync_c (
        .clk_sys(clk_sys),
        .rst(any_rst),
        .async_in(pin_c_in),
        .sync_out(sync_c)
    );

    // ==========================================================
    // Bus decode
    logic [9:0] idx;
    logic [7:0] wd;
    logic rd_take;
    logic wr_fire;
    logic osc_lock;
    logic [7:0] rd_d;

    assign idx = avs_address[11:2];
    assign wd = avs_writedata[7:0];
    // Read data is captured while waitrequest is still high
    assign rd_take = avs_read & avs_waitrequest;
    // Write lands on the edge the master sees waitrequest low
    assign wr_fire = avs_write & ~avs_waitrequest & avs_byteenable[0];
    assign osc_lock = osc_mode_t'(cfg_q[3:2]) != OSC_INT;

    function automatic logic wr_to(input logic [9:0] i);
        return wr_fire && (idx == i);
    endfunction

    // Waitrequest drops for one cycle per request
    always_ff @(posedge clk_sys) begin
        if (any_rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
        end
    end

    // Read mux; unmapped and write-only words read as zero
    always_comb begin
        case (idx)
            `IDX_B_DATA: rd_d = sync_b;
            `IDX_C_DATA: rd_d = sync_c;
            `IDX_INTCTL: rd_d = intctl_q;
            `IDX_B_DIR: rd_d = dir_b_q;
            `IDX_C_DIR: rd_d = {osc_lock ? 2'b11 : dir_c_q[7:6], dir_c_q[5:0]};
            `IDX_PULLUP: rd_d = pullup_en_q;
            `IDX_CHG_EN: rd_d = {chg_en_q, 4'h0};
            `IDX_LCDCTL: rd_d = lcdctl_q;
            `IDX_SEG_LO: rd_d = seg_lo_q;
            `IDX_SEG_HI: rd_d = seg_hi_q;
            `IDX_PORT_CFG: rd_d = {4'h0, cfg_q};
            `IDX_IRQ_STS: rd_d = {6'h00, irq_sts_q};
            `IDX_IRQ_EN: rd_d = {6'h00, irq_en_q};
            default: rd_d = 8'h00;
        endcase
    end

    // Read data register, held until the next read
    always_ff @(posedge clk_sys) begin
        if (any_rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_take) begin
            avs_readdata <= {24'h00_0000, rd_d};
        end
    end

    // ==========================================================
    // Port latches and directions
    always_ff @(posedge clk_sys) begin
        if (any_rst) begin
            lat_b_q <= `RST_LATCH;
            lat_c_q <= `RST_LATCH;
        end else begin
            // Latch takes the bus data, not the pins
            if (wr_to(`IDX_B_DATA)) begin
                lat_b_q <= wd;
            end
            if (wr_to(`IDX_C_DATA)) begin
                lat_c_q <= wd;
            end
        end
    end

    // Directions reset to all inputs
    always_ff @(posedge clk_sys) begin
        if (any_rst) begin
            dir_b_q <= `RST_DIR;
            dir_c_q <= `RST_DIR;
        end else begin
            if (wr_to(`IDX_B_DIR)) begin
                dir_b_q <= wd;
            end
            if (wr_to(`IDX_C_DIR)) begin
                dir_c_q <= wd;
            end
        end
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge clk_sys) begin
        if (any_rst) begin
            pullup_en_q <= `RST_PULLUP;
            chg_en_q <= `RST_CHG_EN;
            lcdctl_q <= `RST_LCDCTL;
            cfg_q <= `RST_CFG;
            irq_en_q <= '0;
        end else begin
            if (wr_to(`IDX_PULLUP)) begin
                pullup_en_q <= wd;
            end
            if (wr_to(`IDX_CHG_EN)) begin
                chg_en_q <= wd[7:4];
            end
            if (wr_to(`IDX_LCDCTL)) begin
                lcdctl_q <= wd;
            end
            if (wr_to(`IDX_PORT_CFG)) begin
                cfg_q <= wd[3:0];
            end
            if (wr_to(`IDX_IRQ_EN)) begin
                irq_en_q <= wd[`IRQ_W-1:0];
            end
        end
    end

    // Segment enables survive the ordinary reset
    always_ff @(posedge clk_sys) begin
        if (por_bor_rst) begin
            seg_lo_q <= `RST_SEG;
            seg_hi_q <= `RST_SEG;
        end else begin
            if (wr_to(`IDX_SEG_LO)) begin
                seg_lo_q <= wd;
            end
            if (wr_to(`IDX_SEG_HI)) begin
                seg_hi_q <= wd;
            end
        end
    end

    // ==========================================================
    // Edge interrupt and change detection
    logic edge_rise;
    logic edge_fall;
    logic ext_evt;
    logic chg_evt;
    logic [`IRQ_W-1:0] evt;
    logic [`IRQ_W-1:0] clr;

    // Pin 0 of the first port seen through the synchroniser
    assign edge_rise = sync_b[0] & ~b_prev_q[0];
    assign edge_fall = ~sync_b[0] & b_prev_q[0];
    assign ext_evt = cfg_q[`CFG_EDGE_RISE] ? edge_rise : edge_fall;
    assign chg_evt = |((sync_b ^ b_prev_q) & {chg_en_q, 4'h0});
    assign evt = {chg_evt, ext_evt};
    assign clr = wr_to(`IDX_IRQ_CLR) ? wd[`IRQ_W-1:0] : '0;

    // Previous pin levels for edge and change compare
    always_ff @(posedge clk_sys) begin
        if (any_rst) begin
            b_prev_q <= '0;
        end else begin
            b_prev_q <= sync_b;
        end
    end

    // Flags in the control word; a new event beats a clearing write
    always_ff @(posedge clk_sys) begin
        if (any_rst) begin
            intctl_q <= `RST_INTCTL;
        end else begin
            if (wr_to(`IDX_INTCTL)) begin
                intctl_q <= wd;
            end
            if (ext_evt) begin
                intctl_q[`INTCTL_EXT_FLAG] <= 1'b1;
            end
            if (chg_evt) begin
                intctl_q[`INTCTL_CHG_FLAG] <= 1'b1;
            end
        end
    end

    // Sticky status; set wins over clear
    always_ff @(posedge clk_sys) begin
        if (any_rst) begin
            irq_sts_q <= '0;
        end else begin
            irq_sts_q <= (irq_sts_q & ~clr) | evt;
        end
    end

    // Level interrupt while an enabled status bit is set
    always_ff @(posedge clk_sys) begin
        if (any_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_sts_q & irq_en_q);
        end
    end

    // ==========================================================
    // Pin ownership
    logic lcd_en;
    logic [`PORT_W-1:0] lcd_b;
    logic [`PORT_W-1:0] lcd_c;
    periph_drive_t b_eff;
    periph_drive_t c_eff;
    pin_drive_t b_next;
    pin_drive_t c_next;

    assign lcd_en = lcdctl_q[`LCD_EN_BIT];
    // Segment lines 0-3, commons 0-1, segments 14 and 13
    assign lcd_b[3:0] = lcd_en ? seg_lo_q[3:0] : 4'h0;
    assign lcd_b[4] = lcd_en;
    assign lcd_b[5] = lcd_en & (lcdctl_q[1:0] != 2'b00);
    assign lcd_b[6] = lcd_en & seg_hi_q[6];
    assign lcd_b[7] = lcd_en & seg_hi_q[5];
    // Bias inputs 1-3, then segments 6, 11, 10, 9, 8
    assign lcd_c[2:0] = {3{lcdctl_q[`LCD_BIAS_EN_BIT]}};
    assign lcd_c[3] = lcd_en & seg_lo_q[6];
    assign lcd_c[4] = lcd_en & seg_hi_q[3];
    assign lcd_c[5] = lcd_en & seg_hi_q[2];
    assign lcd_c[6] = lcd_en & seg_hi_q[1];
    assign lcd_c[7] = lcd_en & seg_hi_q[0];

    // LCD-owned pins leave the digital buffer off for the analog line
    assign b_eff.own = b_alt.own | lcd_b;
    assign b_eff.out = b_alt.out;
    assign b_eff.oe_n = b_alt.oe_n | lcd_b;
    assign c_eff.own = c_alt.own | lcd_c;
    assign c_eff.out = c_alt.out;
    assign c_eff.oe_n = c_alt.oe_n | lcd_c;

    port_pin_mux u_mux_b (
        .latch(lat_b_q),
        .dir(dir_b_q),
        .alt(b_eff),
        .drive(b_next)
    );

    port_pin_mux u_mux_c (
        .latch(lat_c_q),
        .dir(dir_c_q),
        .alt(c_eff),
        .drive(c_next)
    );

    // ==========================================================
    // Pin output registers; everything tri-stated in reset
    always_ff @(posedge clk_sys) begin
        if (any_rst) begin
            pin_b_drive <= '{out: 8'h00, oe_n: 8'hFF};
            pin_c_drive <= '{out: 8'h00, oe_n: 8'hFF};
            pin_b_lcd_own <= 8'h00;
            pin_c_lcd_own <= 8'h00;
        end else begin
            pin_b_drive <= b_next;
            pin_c_drive <= c_next;
            pin_b_lcd_own <= lcd_b;
            pin_c_lcd_own <= lcd_c;
        end
    end

    // Pull-ups need the global enable and an input pin
    always_ff @(posedge clk_sys) begin
        if (any_rst) begin
            pin_b_pullup <= 8'h00;
        end else if (cfg_q[`CFG_PULLUP_EN]) begin
            pin_b_pullup <= pullup_en_q & dir_b_q;
        end else begin
            pin_b_pullup <= 8'h00;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (any_rst);

    property p_pullup_follows;
        (cfg_q[`CFG_PULLUP_EN] && dir_b_q == 8'hFF) |=> (pin_b_pullup == $past(pullup_en_q));
    endproperty
    a_pullup_follows: assert property (p_pullup_follows)
        else $error("pull-up does not follow enable bits");

    property p_global_off;
        !cfg_q[`CFG_PULLUP_EN] |=> (pin_b_pullup == 8'h00);
    endproperty
    a_global_off: assert property (p_global_off)
        else $error("pull-up on without global enable");

    property p_out_no_pullup;
        1'b1 |=> ((pin_b_pullup & ~$past(dir_b_q)) == 8'h00);
    endproperty
    a_out_no_pullup: assert property (p_out_no_pullup)
        else $error("pull-up on an output pin");

    property p_latch_write;
        wr_to(`IDX_C_DATA) |=> (lat_c_q == $past(wd)) ##1 (pin_c_drive.out == (lat_c_q & ~$past(c_eff.own)
            | $past(c_eff.out, 1) & $past(c_eff.own)));
    endproperty
    a_latch_write: assert property (p_latch_write)
        else $error("second port latch not updated");

    property p_drive_only_out;
        1'b1 |=> ((~pin_c_drive.oe_n & ~$past(c_eff.own) & $past(dir_c_q)) == 8'h00);
    endproperty
    a_drive_only_out: assert property (p_drive_only_out)
        else $error("input pin driven from latch");

    property p_dir_reset;
        @(posedge clk_sys) disable iff (1'b0) rst |=> (dir_c_q == 8'hFF)
            ##1 ((pin_c_drive.oe_n | $past(c_alt.own & ~c_alt.oe_n)) == 8'hFF);
    endproperty
    a_dir_reset: assert property (p_dir_reset)
        else $error("direction not all inputs after reset");

    property p_osc_lock;
        (rd_take && idx == `IDX_C_DIR && osc_lock) |=> (avs_readdata[7:6] == 2'b11) && !avs_waitrequest;
    endproperty
    a_osc_lock: assert property (p_osc_lock)
        else $error("locked direction bits read as zero");

    property p_pin_read;
        (rd_take && idx == `IDX_C_DATA) |=> (avs_readdata[7:0] == $past(sync_c));
    endproperty
    a_pin_read: assert property (p_pin_read)
        else $error("data read not from pins");

    property p_ext_irq;
        ext_evt |=> irq_sts_q[`IRQ_EXT] && intctl_q[`INTCTL_EXT_FLAG];
    endproperty
    a_ext_irq: assert property (p_ext_irq)
        else $error("edge on pin 0 not flagged");

    property p_common_own;
        lcd_en |=> pin_b_lcd_own[4] && pin_b_drive.oe_n[4];
    endproperty
    a_common_own: assert property (p_common_own)
        else $error("common line not taken by LCD");

    property p_seg_keep;
        @(posedge clk_sys) disable iff (por_bor_rst) rst |=> (seg_lo_q == $past(seg_lo_q))
            && (seg_hi_q == $past(seg_hi_q));
    endproperty
    a_seg_keep: assert property (p_seg_keep)
        else $error("segment enable lost on ordinary reset");

endmodule
`default_nettype wire

/* File: logic/gpio_params.svh */
// Register indices, field positions and reset values of the GPIO block.
// Assumes the package and the design modules include it by bare name.
// ==========================================================
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

// ==========================================================
// Port width
`define PORT_W 8

// ==========================================================
// Register indices; byte address is four times the index
`define IDX_B_DATA 10'h006
`define IDX_C_DATA 10'h007
`define IDX_INTCTL 10'h00B
`define IDX_B_DIR 10'h086
`define IDX_C_DIR 10'h087
`define IDX_PULLUP 10'h095
`define IDX_CHG_EN 10'h096
`define IDX_LCDCTL 10'h107
`define IDX_SEG_LO 10'h11C
`define IDX_SEG_HI 10'h11D
`define IDX_PORT_CFG 10'h120
`define IDX_IRQ_STS 10'h121
`define IDX_IRQ_CLR 10'h122
`define IDX_IRQ_EN 10'h123

// ==========================================================
// Field positions
`define INTCTL_CHG_FLAG 0
`define INTCTL_EXT_FLAG 1
`define LCD_EN_BIT 7
`define LCD_BIAS_EN_BIT 4
`define CFG_PULLUP_EN 0
`define CFG_EDGE_RISE 1
`define IRQ_EXT 0
`define IRQ_CHG 1
`define IRQ_W 2

// ==========================================================
// Reset values
`define RST_LATCH 8'h00
`define RST_DIR 8'hFF
`define RST_PULLUP 8'hFF
`define RST_CHG_EN 4'h0
`define RST_INTCTL 8'h00
`define RST_LCDCTL 8'h13
`define RST_SEG 8'h00
`define RST_CFG 4'h0

`endif

/* File: logic/gpio_pkg.sv */
// Types shared by the GPIO block modules.
// Assumes gpio_params.svh for widths.
`default_nettype none
`include "gpio_params.svh"
package gpio_pkg;

    // Oscillator selection; all but internal force two direction bits to read back as ones
    typedef enum logic [1:0] {
        OSC_INT = 2'b00,
        OSC_XTAL = 2'b01,
        OSC_HS = 2'b10,
        OSC_LP = 2'b11
    } osc_mode_t;

    // Drive of one port onto its pins; oe_n low means driven
    typedef struct packed {
        logic [`PORT_W-1:0] out;
        logic [`PORT_W-1:0] oe_n;
    } pin_drive_t;

    // Alternate owner of a port's pins
    typedef struct packed {
        logic [`PORT_W-1:0] own;
        logic [`PORT_W-1:0] out;
        logic [`PORT_W-1:0] oe_n;
    } periph_drive_t;

endpackage
`default_nettype wire

/* File: logic/pin_sync.sv */
// Two-flop synchroniser for pin levels.
// Assumes levels may change at any time relative to clk_sys.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule
`default_nettype wire

/* File: logic/port_pin_mux.sv */
// Per-pin choice between the GPIO latch and an alternate owner.
// Assumes the caller registers the result before the pins.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_params.svh"
module port_pin_mux import gpio_pkg::*; (
    // Software side
    input wire logic [`PORT_W-1:0] latch,
    input wire logic [`PORT_W-1:0] dir,
    // Alternate owner
    input wire periph_drive_t alt,
    // Next pin drive
    output wire pin_drive_t drive
);

    // Owned pins follow the owner, others the latch and direction
    for (genvar i = 0; i < `PORT_W; i++) begin : g_pin
        assign drive.out[i] = alt.own[i] ? alt.out[i] : latch[i];
        assign drive.oe_n[i] = alt.own[i] ? alt.oe_n[i] : dir[i];
    end

endmodule
`default_nettype wire

/* File: dv/pin_world.sv */
// Board-side model of one 8-pin port: drivers, pull-ups and floating lines.
// Assumes the drive struct from gpio_pkg and one clock for the float pattern.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_params.svh"
module pin_world import gpio_pkg::*; (
    // Clock
    input wire logic clk_sys,
    // Device side
    input wire pin_drive_t drive,
    input wire logic [`PORT_W-1:0] pull_on,
    input wire logic [`PORT_W-1:0] lcd_own,
    // Board drivers
    input wire logic [`PORT_W-1:0] ext_val,
    input wire logic [`PORT_W-1:0] ext_en,
    // Resolved levels
    output logic [`PORT_W-1:0] level
);
    logic [`PORT_W-1:0] float_q = 8'h55;

    // Undriven lines wander so a stale value never looks valid
    always @(posedge clk_sys) begin
        float_q <= ~float_q;
    end

    // Device drive wins, then board driver, then pull-up
    always_comb begin
        for (int i = 0; i < `PORT_W; i++) begin
            if (drive.oe_n[i] === 1'b0 && lcd_own[i] !== 1'b1) level[i] = drive.out[i];
            else if (ext_en[i]) level[i] = ext_val[i];
            else if (pull_on[i]) level[i] = 1'b1;
            else level[i] = float_q[i];
        end
    end
endmodule
`default_nettype wire

/* File: dv/dual_port_gpio_with_pullups_test.sv */
// Self-checking bench for the two-port GPIO block.
// Assumes gpio_top, gpio_pkg and pin_world are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_params.svh"
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin n_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module dual_port_gpio_with_pullups_test import gpio_pkg::*;;
    // ==========================================================
    // Stimulus and observation signals
    logic clk_sys = 1'b0, rst = 1'b1, por_bor_rst = 1'b1;
    logic [11:0] avs_address = 12'h000;
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, irq;
    logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
    logic [3:0] avs_byteenable = 4'hF;
    logic [7:0] pin_b_in, pin_c_in, pin_b_pullup, pin_b_lcd_own, pin_c_lcd_own, q;
    logic [7:0] ext_b_val = 8'h00, ext_c_val = 8'h00, ext_b_en = 8'hFF;
    pin_drive_t pin_b_drive, pin_c_drive;
    periph_drive_t c_alt = '0;
    logic [31:0] seed = 32'h00012F12;
    int n_errors = 0, n_tests = 0;

    // 10 MHz system clock
    always #50 clk_sys = ~clk_sys;

    gpio_top uut (.clk_sys(clk_sys), .rst(rst), .por_bor_rst(por_bor_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq), .pin_b_in(pin_b_in), .pin_b_drive(pin_b_drive), .pin_b_pullup(pin_b_pullup),
        .pin_b_lcd_own(pin_b_lcd_own), .pin_c_in(pin_c_in), .pin_c_drive(pin_c_drive),
        .pin_c_lcd_own(pin_c_lcd_own), .b_alt('0), .c_alt(c_alt));

    // Board drives every pin it can so edge events stay under control
    pin_world wb (.clk_sys(clk_sys), .drive(pin_b_drive), .pull_on(pin_b_pullup), .lcd_own(pin_b_lcd_own),
        .ext_val(ext_b_val), .ext_en(ext_b_en), .level(pin_b_in));
    pin_world wc (.clk_sys(clk_sys), .drive(pin_c_drive), .pull_on(8'h00), .lcd_own(pin_c_lcd_own),
        .ext_val(ext_c_val), .ext_en(8'hFF), .level(pin_c_in));

    // ==========================================================
    // Expectations and random source
    function automatic logic [7:0] rnd();
        for (int k = 0; k < 8; k++) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    function automatic logic [7:0] exp_pull(input logic [7:0] p, input logic [7:0] d, input logic g);
        return g ? (p & d) : 8'h00;
    endfunction
    function automatic logic [7:0] exp_pin(input logic [7:0] l, input logic [7:0] d, input logic [7:0] e);
        return (l & ~d) | (e & d);
    endfunction

    // ==========================================================
    // Bus master: hold the request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] d);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h000000, d};
        @(posedge clk_sys);
        // Only the watchdog ends a wait that never gets its answer
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk_sys);
        end
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd_chk(input logic [9:0] idx, input logic [7:0] ex);
        bus(1'b0, idx, 8'h00);
        `CHK("register read", ex, q)
    endtask
    task automatic waitn(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    task automatic pulse(input logic por);
        if (por) por_bor_rst <= 1'b1;
        else rst <= 1'b1;
        waitn(2);
        rst <= 1'b0;
        por_bor_rst <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic final_report();
        $display("Counts: %0d comparisons, %0d mismatches", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        final_report();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [9:0] ri [10];
        logic [7:0] rv [10];
        logic [7:0] l, d, e, p;
        ri = '{`IDX_B_DIR, `IDX_C_DIR, `IDX_PULLUP, `IDX_CHG_EN, `IDX_LCDCTL, `IDX_SEG_LO, `IDX_SEG_HI,
            `IDX_INTCTL, `IDX_IRQ_STS, 10'h200};
        rv = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h13, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        por_bor_rst <= 1'b0;
        waitn(2);
        for (int i = 0; i < 10; i++) rd_chk(ri[i], rv[i]);
        `CHK("c lcd own", 8'h07, pin_c_lcd_own)
        `CHK("b pullup", 8'h00, pin_b_pullup)
        `CHK("c oe_n", 8'hFF, pin_c_drive.oe_n)
        // Write with the low byte lane off must be dropped
        avs_byteenable <= 4'hE;
        bus(1'b1, `IDX_B_DIR, 8'h00);
        avs_byteenable <= 4'hF;
        rd_chk(`IDX_B_DIR, 8'hFF);
        $display("reset and map test done");

        // Random latch, direction and pull-up mixes, all-in and all-out first
        bus(1'b1, `IDX_LCDCTL, 8'h00);
        for (int i = 0; i < 6; i++) begin
            l = rnd();
            d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : rnd();
            e = rnd();
            p = rnd();
            ext_c_val <= e;
            bus(1'b1, `IDX_C_DATA, l);
            bus(1'b1, `IDX_C_DIR, d);
            bus(1'b1, `IDX_PULLUP, p);
            bus(1'b1, `IDX_B_DIR, d);
            bus(1'b1, `IDX_PORT_CFG, {7'h00, ~i[0]});
            waitn(4);
            `CHK("c oe_n", d, pin_c_drive.oe_n)
            `CHK("c out", l & ~d, pin_c_drive.out & ~d)
            `CHK("b pullup", exp_pull(p, d, ~i[0]), pin_b_pullup)
            rd_chk(`IDX_C_DATA, exp_pin(l, d, e));
        end
        // Released first-port lines read high only through an active pull-up
        bus(1'b1, `IDX_B_DIR, 8'hF0);
        bus(1'b1, `IDX_PULLUP, 8'hF0);
        bus(1'b1, `IDX_PORT_CFG, 8'h01);
        ext_b_en <= 8'h0F;
        ext_b_val <= 8'h0F;
        waitn(4);
        `CHK("b oe_n", 8'hF0, pin_b_drive.oe_n)
        `CHK("b pullup", 8'hF0, pin_b_pullup)
        rd_chk(`IDX_B_DATA, 8'hF0);
        ext_b_en <= 8'hFF;
        ext_b_val <= 8'h00;
        $display("port data test done");

        // Oscillator modes lock the top two direction bits on readback
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, `IDX_PORT_CFG, {4'h0, m[1:0], 2'b00});
            bus(1'b1, `IDX_C_DIR, 8'h00);
            rd_chk(`IDX_C_DIR, (m != 0) ? 8'hC0 : 8'h00);
        end
        $display("oscillator test done");

        // Edge interrupt on pin 0: raise, clear, mask, falling select
        bus(1'b1, `IDX_B_DIR, 8'hFF);
        bus(1'b1, `IDX_PORT_CFG, 8'h02);
        bus(1'b1, `IDX_IRQ_EN, 8'h01);
        ext_b_val <= 8'h01;
        waitn(6);
        `CHK("irq", 1'b1, irq)
        rd_chk(`IDX_IRQ_STS, 8'h01);
        bus(1'b1, `IDX_IRQ_CLR, 8'h01);
        waitn(2);
        `CHK("irq", 1'b0, irq)
        bus(1'b1, `IDX_IRQ_EN, 8'h00);
        ext_b_val <= 8'h00;
        waitn(4);
        rd_chk(`IDX_IRQ_STS, 8'h00);
        ext_b_val <= 8'h01;
        waitn(6);
        `CHK("irq", 1'b0, irq)
        bus(1'b1, `IDX_IRQ_EN, 8'h01);
        waitn(2);
        `CHK("irq", 1'b1, irq)
        bus(1'b1, `IDX_IRQ_CLR, 8'h01);
        bus(1'b1, `IDX_PORT_CFG, 8'h00);
        ext_b_val <= 8'h00;
        waitn(6);
        rd_chk(`IDX_IRQ_STS, 8'h01);
        // Change on an enabled upper pin sets only the change flag
        bus(1'b1, `IDX_CHG_EN, 8'h10);
        bus(1'b1, `IDX_IRQ_CLR, 8'h03);
        ext_b_val <= 8'h10;
        waitn(6);
        rd_chk(`IDX_IRQ_STS, 8'h02);
        $display("interrupt test done");

        // LCD common, bias and alternate owners
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, `IDX_LCDCTL, (i == 0) ? 8'h80 : (i == 1) ? 8'h83 : 8'h10);
            waitn(2);
            `CHK("b common own", (i == 0) ? 2'b01 : (i == 1) ? 2'b11 : 2'b00, pin_b_lcd_own[5:4])
            `CHK("c bias own", (i == 2) ? 3'h7 : 3'h0, pin_c_lcd_own[2:0])
        end
        bus(1'b1, `IDX_LCDCTL, 8'h00);
        bus(1'b1, `IDX_C_DIR, 8'hFF);
        c_alt <= {8'h01, 8'h01, 8'h00};
        waitn(3);
        `CHK("c alt drive", 2'b10, {pin_c_drive.out[0], pin_c_drive.oe_n[0]})
        c_alt <= '0;
        $display("pin sharing test done");

        // Segment enables survive ordinary reset only
        bus(1'b1, `IDX_SEG_LO, 8'hA5);
        bus(1'b1, `IDX_C_DIR, 8'h0F);
        pulse(1'b0);
        rd_chk(`IDX_SEG_LO, 8'hA5);
        rd_chk(`IDX_C_DIR, 8'hFF);
        pulse(1'b1);
        rd_chk(`IDX_SEG_LO, 8'h00);
        $display("reset source test done");
        final_report();
    end
endmodule
`default_nettype wire
